// file: hw/scwp_pin_sync.sv
// Two-flop synchroniser with start, stop and clock edge detection
`timescale 1ns/1ps
module scwp_pin_sync (
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output scwp_pkg::scwp_bus_ev_s     ev_o
);
  logic [1:0] scl_meta_q, scl_meta_d;
  logic [1:0] sda_meta_q, sda_meta_d;
  logic       scl_q,      scl_d;
  logic       sda_q,      sda_d;

  always_comb begin
    scl_meta_d = {scl_meta_q[0], scl_i};
    sda_meta_d = {sda_meta_q[0], sda_i};
    scl_d      = scl_meta_q[1];
    sda_d      = sda_meta_q[1];
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else if (clk_en_i) begin
      scl_meta_q <= scl_meta_d;
      sda_meta_q <= sda_meta_d;
      scl_q      <= scl_d;
      sda_q      <= sda_d;
    end
  end

  // Only the second stage and the delayed copy feed edge logic
  always_comb begin
    ev_o.start = scl_q && scl_meta_q[1] && sda_q && !sda_meta_q[1];
    ev_o.stop  = scl_q && scl_meta_q[1] && !sda_q && sda_meta_q[1];
    ev_o.rise  = !scl_q && scl_meta_q[1];
    ev_o.fall  = scl_q && !scl_meta_q[1];
    ev_o.sda   = sda_meta_q[1];
  end
endmodule : scwp_pin_sync

// file: hw/scwp_pkg.sv
// Types for the serial configuration port
package scwp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } scwp_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } scwp_bus_ev_s;

endpackage : scwp_pkg

// file: hw/scwp_port.sv
// Serial slave port writing and reading the output-enable register
// What this block does
// - Port works for write and read up to 400 kbit/s.
// - Write: start, address, direction, ack, pointer, ack, data with acks.
// - Each later data byte goes to pointer plus one until stop.
// - Data sampled while clock high, changed only while clock low.
// - Data falling while clock high marks a frame start.
// - Data rising while clock high marks a stop, freeing the bus.
// - Device pulls data low on the ninth clock of each written byte.
// - Register 09h holds six enable bits; bits 7 and 6 read zero.
`timescale 1ns/1ps
`include "scwp_regs.svh"
module scwp_port #(
  parameter logic [6:0] DEV_ADDR = `SCWP_DEV_ADDR
) (
  input  wire logic                     clock_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     clk_en_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  output logic [`SCWP_OE_W-1:0]         output_enable_bits_o,
  output logic [7:0]                    register_pointer_o
);
  scwp_pkg::scwp_bus_ev_s ev;
  scwp_pkg::scwp_state_e  st_q,   st_d;
  logic [3:0]             bit_q,  bit_d;
  logic [7:0]             sh_q,   sh_d;
  logic [7:0]             ptr_q,  ptr_d;
  logic [`SCWP_OE_W-1:0]  oe_q,   oe_d;
  logic                   drv_q,  drv_d;
  logic                   mack_q, mack_d;
  logic [7:0]             rd_byte;
  logic                   active;
  logic                   byte_end;
  logic                   addr_hit;

  // Edge driven with no bit timer, so any slower bit rate works too
  scwp_pin_sync u_sync (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_i),
    .clk_en_i (clk_en_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .ev_o     (ev)
  );

  // Only one register exists; other addresses read back as zero
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == `SCWP_OE_ADDR) begin
      rd_byte = {2'h0, oe_q};
    end
  end

  // Clock edges count during any address byte and inside a frame addressed to this port
  always_comb begin
    active   = (st_q != scwp_pkg::ST_IDLE) &&
               (st_q != scwp_pkg::ST_IGNORE);
    byte_end = active && ev.fall && (bit_q == 4'h7);
    addr_hit = (sh_q[7:1] == DEV_ADDR);
  end

  // Frame state and bit position within the nine-clock segment
  always_comb begin
    st_d  = st_q;
    bit_d = bit_q;
    if (ev.start) begin
      st_d  = scwp_pkg::ST_ADDR;
      // The start's own clock fall wraps this to bit zero
      bit_d = 4'hF;
    end else if (ev.stop) begin
      st_d = scwp_pkg::ST_IDLE;
    end else if (active && ev.fall) begin
      bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      case (st_q)
        scwp_pkg::ST_ADDR: begin
          if (bit_q == 4'h7 && !addr_hit) begin
            st_d = scwp_pkg::ST_IGNORE;
          end else if (bit_q == 4'h8) begin
            // Reads start at the pointer left by an earlier write
            st_d = sh_q[0] ? scwp_pkg::ST_RDATA : scwp_pkg::ST_PTR;
          end
        end
        scwp_pkg::ST_PTR: begin
          if (bit_q == 4'h8) begin
            st_d = scwp_pkg::ST_WDATA;
          end
        end
        scwp_pkg::ST_RDATA: begin
          // A master that does not acknowledge ends the read
          if (bit_q == 4'h8 && !mack_q) begin
            st_d = scwp_pkg::ST_IGNORE;
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q  <= scwp_pkg::ST_IDLE;
      bit_q <= 4'h0;
    end else if (clk_en_i) begin
      st_q  <= st_d;
      bit_q <= bit_d;
    end
  end

  // Data is stable while the clock is high, so sample on its rise
  always_comb begin
    sh_d   = sh_q;
    mack_d = mack_q;
    if (active && ev.rise) begin
      if (bit_q < 4'h8) begin
        sh_d = {sh_q[6:0], ev.sda};
      end else begin
        mack_d = !ev.sda;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh_q   <= 8'h00;
      mack_q <= 1'b0;
    end else if (clk_en_i) begin
      sh_q   <= sh_d;
      mack_q <= mack_d;
    end
  end

  // Pointer is loaded by the second byte and steps once per data byte
  always_comb begin
    ptr_d = ptr_q;
    if (byte_end) begin
      case (st_q)
        scwp_pkg::ST_PTR: begin
          ptr_d = sh_q;
        end
        scwp_pkg::ST_WDATA, scwp_pkg::ST_RDATA: begin
          ptr_d = ptr_q + 8'h01;
        end
        default: begin
          ptr_d = ptr_q;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_q <= 8'h00;
    end else if (clk_en_i) begin
      ptr_q <= ptr_d;
    end
  end

  // Bytes for any other address are acknowledged but dropped
  always_comb begin
    oe_d = oe_q;
    if (byte_end && st_q == scwp_pkg::ST_WDATA &&
        ptr_q == `SCWP_OE_ADDR) begin
      oe_d = sh_q[`SCWP_OE_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oe_q <= `SCWP_OE_W'(`SCWP_OE_RESET);
    end else if (clk_en_i) begin
      oe_q <= oe_d;
    end
  end

  // Our drive changes just after the clock falls, and is released at a start or stop
  always_comb begin
    drv_d = drv_q;
    if (ev.start || ev.stop) begin
      drv_d = 1'b0;
    end else if (active && ev.fall) begin
      drv_d = 1'b0;
      case (st_q)
        scwp_pkg::ST_ADDR: begin
          if (bit_q == 4'h7) begin
            drv_d = addr_hit;
          end else if (bit_q == 4'h8 && sh_q[0]) begin
            drv_d = !rd_byte[7];
          end
        end
        scwp_pkg::ST_PTR, scwp_pkg::ST_WDATA: begin
          if (bit_q == 4'h7) begin
            drv_d = 1'b1;
          end
        end
        scwp_pkg::ST_RDATA: begin
          if (bit_q < 4'h7) begin
            drv_d = !rd_byte[3'(4'h6 - bit_q)];
          end else if (bit_q == 4'h8 && mack_q) begin
            drv_d = !rd_byte[7];
          end
        end
        default: begin
          drv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drv_q <= 1'b0;
    end else if (clk_en_i) begin
      drv_q <= drv_d;
    end
  end

  // Open drain: only ever pull low
  assign sda_o                = 1'b0;
  assign sda_oe_o             = drv_q;
  assign output_enable_bits_o = oe_q;
  assign register_pointer_o   = ptr_q;
endmodule : scwp_port

// file: hw/scwp_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SCWP_REGS_SVH
`define SCWP_REGS_SVH

`define SCWP_OE_ADDR        8'h09
`define SCWP_OE_RESET       8'h00
`define SCWP_OE_WR_MASK     8'h3F
`define SCWP_OE_W           6
`define SCWP_DEV_ADDR       7'h69
`define SCWP_MAX_RATE_KBPS  400
`define SCWP_CLK_MHZ        125
`define SCWP_MIN_BIT_CYC    ((`SCWP_CLK_MHZ * 1000) / `SCWP_MAX_RATE_KBPS)

`endif

// file: tb/scwp_master.sv
// Two-wire bus master model; clock stands high between frames
`timescale 1ns/1ps
module scwp_master (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Pins move 1 ns after a clock edge; 2+3+2+3 cycles make 80 ns
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step
  task automatic bit_x(input logic b, output logic r);
    step(2);
    sda_o = b;
    step(3);
    scl_o = 1'b1;
    step(2);
    r = sda_i;
    step(3);
    scl_o = 1'b0;
  endtask : bit_x
  // Also serves as repeated start from clock low
  task automatic start;
    step(2);
    sda_o = 1'b1;
    step(3);
    scl_o = 1'b1;
    step(2);
    sda_o = 1'b0;
    step(3);
    scl_o = 1'b0;
  endtask : start
  task automatic stop;
    step(2);
    sda_o = 1'b0;
    step(3);
    scl_o = 1'b1;
    step(2);
    sda_o = 1'b1;
    step(3);
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic m9,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(m9, a);
  endtask : xfer
endmodule : scwp_master

// file: tb/scwp_port_sva.sv
// Pin-level checks on the serial configuration port
`timescale 1ns/1ps
module scwp_port_sva (
  input wire logic       clock_i,
  input wire logic       rst_b_i,
  input wire logic       clk_en_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [5:0] output_enable_bits_o,
  input wire logic [7:0] register_pointer_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  rst_val_a: assert property ($rose(rst_b_i) |-> !sda_oe_o &&
    output_enable_bits_o == 6'h00 && register_pointer_o == 8'h00)
    else $error("bad reset state");
  od_low_a: assert property (sda_o == 1'b0)
    else $error("data driven high");
  oe_move_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data moved in clock high");
  ack_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o[*5])
    else $error("drive too short");
  stop_rel_a: assert property (scl_i && $rose(sda_i) |->
    ##[1:8] !sda_oe_o) else $error("line held after stop");
  ptr_move_a: assert property ($changed(register_pointer_o) |->
    !scl_i) else $error("pointer moved in clock high");
  oe_bits_a: assert property ($changed(output_enable_bits_o) |->
    !scl_i && $past(register_pointer_o) == 8'h09)
    else $error("enables written elsewhere");
  freeze_a: assert property (!clk_en_i |=>
    $stable(output_enable_bits_o)) else $error("enables moved frozen");
endmodule : scwp_port_sva
bind scwp_port scwp_port_sva chk_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .output_enable_bits_o(output_enable_bits_o),
  .register_pointer_o(register_pointer_o));

// file: tb/scwp_port_tb.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
`include "scwp_regs.svh"
module scwp_port_tb;
  logic       clock_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       clk_en_i = 1'b1;
  logic       scl, sda_m, sda_o, sda_oe_o, ack;
  logic [5:0] bits;
  logic [7:0] ptr, q;
  int         n_errors = 0, check_count = 0, cyc = 0;
  // Pull-up: released line reads high
  wire        sda = sda_m & (sda_oe_o ? sda_o : 1'b1);
  initial forever #4 clock_i = ~clock_i;
  scwp_port dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .output_enable_bits_o(bits), .register_pointer_o(ptr));
  scwp_master m_u (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
    .sda_o(sda_m));
  task automatic final_report;
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  // e is the expected ninth-bit level: 0 when acknowledged
  task automatic wb(input logic [7:0] d, input logic e);
    m_u.xfer(d, 1'b1, q, ack);
    chk({7'h00, ack}, {7'h00, e});
  endtask : wb
  task automatic hdr(input logic [6:0] a, input logic [7:0] p, input logic e);
    m_u.start();
    wb({a, 1'b0}, e);
    wb(p, e);
  endtask : hdr
  task automatic t_write;
    hdr(`SCWP_DEV_ADDR, 8'h09, 1'b0);
    wb(8'hFF, 1'b0);
    m_u.stop();
    chk({2'b00, bits}, 8'h3F);
    chk(ptr, 8'h0A);
  endtask : t_write
  // Three writes step the pointer over unused addresses, then one write to 09h
  task automatic t_incr;
    hdr(`SCWP_DEV_ADDR, 8'h40, 1'b0);
    wb(8'h11, 1'b0);
    wb(8'h22, 1'b0);
    wb(8'h33, 1'b0);
    m_u.stop();
    chk(ptr, 8'h43);
    chk({2'b00, bits}, 8'h3F);
    hdr(`SCWP_DEV_ADDR, 8'h09, 1'b0);
    wb(8'h15, 1'b0);
    m_u.stop();
    chk({2'b00, bits}, 8'h15);
  endtask : t_incr
  task automatic t_foreign;
    hdr(7'h68, 8'h09, 1'b1);
    wb(8'h00, 1'b1);
    m_u.stop();
    chk({2'b00, bits}, 8'h15);
  endtask : t_foreign
  // Pointer only, no data byte, then two reads across it
  task automatic t_read;
    hdr(`SCWP_DEV_ADDR, 8'h08, 1'b0);
    m_u.start();
    wb({`SCWP_DEV_ADDR, 1'b1}, 1'b0);
    m_u.xfer(8'hFF, 1'b0, q, ack);
    chk(q, 8'h00);
    m_u.xfer(8'hFF, 1'b1, q, ack);
    chk(q, 8'h15);
    m_u.stop();
    chk(ptr, 8'h0A);
  endtask : t_read
  task automatic t_freeze;
    @(posedge clock_i) #1 clk_en_i = 1'b0;
    hdr(`SCWP_DEV_ADDR, 8'h09, 1'b1);
    wb(8'h00, 1'b1);
    m_u.stop();
    @(posedge clock_i) #1 clk_en_i = 1'b1;
    chk({2'b00, bits}, 8'h15);
  endtask : t_freeze
  task automatic t_reset;
    @(posedge clock_i) #1 rst_b_i = 1'b0;
    @(posedge clock_i) #1 rst_b_i = 1'b1;
    chk({2'b00, bits}, 8'h00);
    chk(ptr, 8'h00);
    repeat (3) @(posedge clock_i);
    #1;
  endtask : t_reset
  initial begin
    repeat (3) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    t_write();
    t_incr();
    t_foreign();
    t_read();
    t_freeze();
    t_reset();
    t_write();
    final_report();
  end
endmodule : scwp_port_tb
